// ### design/ccs_codec_dev.sv
// Purpose: Serial port end of one dual codec (two codec units in cascade)
// Assumes: Whole end runs on the link clock; enable and reset arrive from the host
// Notes: Converters are modelled by a sample FIFO in and DAC words out
//
// What this block does
// - Host registers enable and reset on master clock
// - Data and frame sync chain to next device
// - All devices share one serial clock
// - Host takes serial clock as external input
// - One 16-bit word per frame sync
// - Frame sync high, one clock before MSB
// - Host frame sync directions depend on loop-back
// - Two sample words sent per sample period
// - Mixed non-loop-back accepts variable word count
// - Host sends control words before DAC word
// - Loop-back control word replaces DAC update
// - Reset starts program mode, no conversions
// - Loop-back init: one word per codec per period
// - Non-loop-back init may fit one period
// - Host writes codec 2 before codec 1
// - Device count resets to zero, host sets one
// - Mode leaves program only via register A
`timescale 1ns/1ps
`include "ccs_consts.svh"
module ccs_codec_dev (
    // Link to the host serial port
    ccs_link_if.dev lnk,
    // Reset, asynchronous
    input wire logic rst_n_i,
    // ADC samples in, on the link clock, codec 2 then codec 1
    input wire logic adc_valid_i,
    input ccs_pkg::ccs_word_t adc_data_i,
    output logic adc_ready_o,
    // DAC words out, updated once per sample period
    output ccs_pkg::ccs_word_t dac_ch1_o,
    output ccs_pkg::ccs_word_t dac_ch2_o,
    output logic dac_load_o,
    // Device count field of codec 1 register A
    output logic [2:0] dev_count_o
);
    // Decodes a register A value into the operating mode
    function automatic ccs_pkg::ccs_mode_t mode_of(input logic [7:0] cra);
        logic [1:0] f;
        f = cra[`CCS_MODE_MSB:`CCS_MODE_LSB];
        if (f == `CCS_MODE_PROG) begin
            mode_of = ccs_pkg::mode_prog;
        end else if (f == `CCS_MODE_DATA) begin
            mode_of = ccs_pkg::mode_data;
        end else begin
            mode_of = ccs_pkg::mode_mixed;
        end
    endfunction

    // Index 0 is codec 1, index 1 is codec 2
    logic [7:0] ctl [2][8];
    ccs_pkg::ccs_word_t dac_reg [2];
    ccs_pkg::ccs_mode_t mode1, mode2;

    logic se_m, se_s, cr_m, cr_s;

    logic [5:0] pcnt, next_pcnt;
    logic [4:0] tbits, next_tbits;
    ccs_pkg::ccs_word_t tsh, next_tsh;
    logic ofs, next_ofs, osd, next_osd;
    logic next_dload, slot_a, slot_b, live;
    ccs_pkg::ccs_word_t next_dac1, next_dac2;

    logic f_valid, f_pop;
    ccs_pkg::ccs_word_t f_data;

    logic [4:0] rbits, next_rbits;
    ccs_pkg::ccs_word_t rsh, next_rsh, word;
    logic didx, next_didx, wr_ctl, wr_dac, pair_prog;
    ccs_pkg::ccs_mode_t tgt_mode;

    assign mode1 = mode_of(ctl[0][`CCS_CRA_INDEX]);
    assign mode2 = mode_of(ctl[1][`CCS_CRA_INDEX]);
    assign dev_count_o = ctl[0][`CCS_CRA_INDEX][`CCS_DEVCNT_MSB:`CCS_DEVCNT_LSB];
    assign lnk.output_frame_sync = ofs;
    assign lnk.serial_data_out_pin = osd;

    // Enable and reset come from the host clock domain
    always_ff @(posedge lnk.sclk or negedge rst_n_i) begin
        if (!rst_n_i) begin
            se_m <= 1'b0;
            se_s <= 1'b0;
            cr_m <= 1'b0;
            cr_s <= 1'b0;
        end else begin
            se_m <= lnk.serial_port_enable_pin;
            se_s <= se_m;
            cr_m <= lnk.codec_rst_n;
            cr_s <= cr_m;
        end
    end

    ccs_fifo #(
        .WIDTH(16),
        .DEPTH(`CCS_FIFO_DEPTH)
    ) u_adc_fifo (
        .clk_i(lnk.sclk),
        .rst_n_i(rst_n_i),
        .in_valid_i(adc_valid_i),
        .in_data_i(adc_data_i),
        .in_ready_o(adc_ready_o),
        .out_valid_o(f_valid),
        .out_data_o(f_data),
        .out_ready_i(f_pop)
    );

    // Transmit framing: two slots per period, codec 2 word first
    always_comb begin
        next_pcnt = pcnt;
        next_ofs = 1'b0;
        next_osd = 1'b0;
        next_tsh = tsh;
        next_tbits = tbits;
        next_dload = 1'b0;
        next_dac1 = dac_ch1_o;
        next_dac2 = dac_ch2_o;
        f_pop = 1'b0;
        slot_a = (pcnt == `CCS_SLOT_A);
        slot_b = (pcnt == `CCS_SLOT_B);
        live = slot_a ? (mode2 != ccs_pkg::mode_prog) : (mode1 != ccs_pkg::mode_prog);
        if (tbits != 5'h0) begin
            next_osd = tsh[15];
            next_tsh = {tsh[14:0], 1'b0};
            next_tbits = tbits - 5'h1;
        end
        if (!cr_s) begin
            next_pcnt = `CCS_SLOT_A;
            next_tbits = 5'h0;
            next_tsh = '0;
            next_osd = 1'b0;
            next_dac1 = '0;
            next_dac2 = '0;
        end else if (se_s) begin
            next_pcnt = (pcnt == `CCS_PCNT_LAST) ? `CCS_SLOT_A : pcnt + 6'h1;
            if (slot_a || slot_b) begin
                // Pulse for one clock; the MSB follows on the next clock
                next_ofs = 1'b1;
                next_tbits = `CCS_WORD_BITS;
                // A codec still in program mode sends zeros and converts nothing
                f_pop = live;
                next_tsh = (live && f_valid) ? f_data : '0;
            end
            // DAC loads just before the first sample leaves
            if (slot_a && (mode1 != ccs_pkg::mode_prog || mode2 != ccs_pkg::mode_prog)) begin
                next_dload = 1'b1;
                if (mode1 != ccs_pkg::mode_prog) begin
                    next_dac1 = dac_reg[0];
                end
                if (mode2 != ccs_pkg::mode_prog) begin
                    next_dac2 = dac_reg[1];
                end
            end
        end
    end

    always_ff @(posedge lnk.sclk or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pcnt <= `CCS_SLOT_A;
            tbits <= 5'h0;
            tsh <= '0;
            ofs <= 1'b0;
            osd <= 1'b0;
            dac_load_o <= 1'b0;
            dac_ch1_o <= '0;
            dac_ch2_o <= '0;
        end else begin
            pcnt <= next_pcnt;
            tbits <= next_tbits;
            tsh <= next_tsh;
            ofs <= next_ofs;
            osd <= next_osd;
            dac_load_o <= next_dload;
            dac_ch1_o <= next_dac1;
            dac_ch2_o <= next_dac2;
        end
    end

    // Receive: frame sync, then 16 bits MSB first; any number per period
    always_comb begin
        next_rbits = rbits;
        next_rsh = rsh;
        next_didx = didx;
        wr_ctl = 1'b0;
        wr_dac = 1'b0;
        word = {rsh[14:0], lnk.serial_data_in_pin};
        tgt_mode = didx ? mode1 : mode2;
        // Control only until both codecs leave program mode, so codec 1 can still be set
        pair_prog = (mode1 == ccs_pkg::mode_prog) || (mode2 == ccs_pkg::mode_prog);
        if (rbits != 5'h0) begin
            next_rsh = word;
            next_rbits = rbits - 5'h1;
            if (rbits == 5'h1) begin
                // Data mode takes every word as DAC; mixed looks at the flag bit
                if (pair_prog ||
                    (tgt_mode == ccs_pkg::mode_mixed && word[`CCS_CTRL_BIT])) begin
                    wr_ctl = 1'b1;
                end else begin
                    wr_dac = 1'b1;
                    next_didx = ~didx;
                end
            end
        end else if (lnk.input_frame_sync && se_s) begin
            next_rbits = `CCS_WORD_BITS;
        end
        // DAC word order restarts each period: codec 2 first
        if (se_s && pcnt == `CCS_SLOT_A) begin
            next_didx = 1'b0;
        end
        if (!cr_s) begin
            next_rbits = 5'h0;
            next_rsh = '0;
            next_didx = 1'b0;
            wr_ctl = 1'b0;
            wr_dac = 1'b0;
        end
    end

    always_ff @(posedge lnk.sclk or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rbits <= 5'h0;
            rsh <= '0;
            didx <= 1'b0;
        end else begin
            rbits <= next_rbits;
            rsh <= next_rsh;
            didx <= next_didx;
        end
    end

    // Control registers and DAC holding registers
    always_ff @(posedge lnk.sclk or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int c = 0; c < 2; c++) begin
                dac_reg[c] <= '0;
                for (int r = 0; r < 8; r++) begin
                    ctl[c][r] <= `CCS_CTL_RST;
                end
            end
        end else if (!cr_s) begin
            for (int c = 0; c < 2; c++) begin
                dac_reg[c] <= '0;
                for (int r = 0; r < 8; r++) begin
                    ctl[c][r] <= `CCS_CTL_RST;
                end
            end
        end else begin
            if (wr_ctl) begin
                // Mode only changes through a write to register A
                ctl[word[`CCS_CODEC_BIT]][word[`CCS_REG_MSB:`CCS_REG_LSB]] <=
                    word[`CCS_DATA_MSB:0];
            end
            if (wr_dac) begin
                // A control word in a DAC slot leaves the old value in place
                dac_reg[~didx] <= word;
            end
        end
    end
endmodule

// ### design/ccs_consts.svh
// Purpose: Shared constants of the cascaded codec serial link
// Assumes: Included by bare name from every design file that needs it
// Notes: Counts are in link clock cycles unless named otherwise
`ifndef CCS_CONSTS_SVH
`define CCS_CONSTS_SVH

// Word format
`define CCS_WORD_BITS 5'h10
`define CCS_CTRL_BIT 15
`define CCS_CODEC_BIT 11
`define CCS_REG_MSB 10
`define CCS_REG_LSB 8
`define CCS_DATA_MSB 7

// Control register A fields
`define CCS_CRA_INDEX 3'h0
`define CCS_MODE_MSB 1
`define CCS_MODE_LSB 0
`define CCS_MODE_PROG 2'h0
`define CCS_MODE_DATA 2'h1
`define CCS_DEVCNT_MSB 7
`define CCS_DEVCNT_LSB 5
`define CCS_CTL_RST 8'h00

// Sample period framing, in link clock cycles
`define CCS_PCNT_LAST 6'h3f
`define CCS_SLOT_A 6'h00
`define CCS_SLOT_B 6'h11

// Sample buffer
`define CCS_FIFO_DEPTH 16

`endif

// ### design/ccs_pkg.sv
// Purpose: Types shared by both ends of the codec serial link
// Assumes: Constants come from ccs_consts.svh
// Notes: Nothing here is imported; users write ccs_pkg::name
package ccs_pkg;
    typedef logic [15:0] ccs_word_t;
    typedef enum logic [1:0] {mode_prog, mode_data, mode_mixed} ccs_mode_t;
endpackage

// ### design/ccs_link_if.sv
// Purpose: Serial wiring between a dual codec and the host serial port
// Assumes: Link clock comes from the bench and feeds both ends
// Notes: Input frame sync is looped from the output frame sync in loop-back framing
`timescale 1ns/1ps
interface ccs_link_if (
    input wire logic sclk
);
    logic output_frame_sync;
    logic serial_data_out_pin;
    logic serial_data_in_pin;
    logic host_tx_fs;
    logic fslb;
    logic serial_port_enable_pin;
    logic codec_rst_n;
    logic input_frame_sync;

    // Loop-back wiring: host transmit frame sync becomes an input
    assign input_frame_sync = fslb ? output_frame_sync : host_tx_fs;

    modport dev (
        input sclk, input_frame_sync, serial_data_in_pin,
        input serial_port_enable_pin, codec_rst_n,
        output output_frame_sync, serial_data_out_pin
    );
    modport host (
        input sclk, output_frame_sync, serial_data_out_pin,
        output serial_data_in_pin, host_tx_fs, fslb,
        output serial_port_enable_pin, codec_rst_n
    );
endinterface

// ### design/ccs_fifo.sv
// Purpose: Synchronous FIFO with valid/ready on both sides
// Assumes: Depth is a power of two
// Notes: Input ready is registered so it can leave a top level directly
`timescale 1ns/1ps
module ccs_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Fill side
    input wire logic in_valid_i,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic in_ready_o,
    // Drain side
    output logic out_valid_o,
    output logic [WIDTH-1:0] out_data_o,
    input wire logic out_ready_i
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp, rp, next_wp, next_rp;
    logic [AW:0] cnt, next_cnt;
    logic next_ready, push, pop;

    assign out_valid_o = (cnt != '0);
    assign out_data_o = mem[rp];

    always_comb begin
        push = in_valid_i && in_ready_o;
        pop = out_valid_o && out_ready_i;
        next_wp = push ? wp + 1'b1 : wp;
        next_rp = pop ? rp + 1'b1 : rp;
        next_cnt = cnt;
        if (push && !pop) begin
            next_cnt = cnt + 1'b1;
        end else if (pop && !push) begin
            next_cnt = cnt - 1'b1;
        end
        next_ready = (next_cnt != (AW+1)'(DEPTH));
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wp <= '0;
            rp <= '0;
            cnt <= '0;
            in_ready_o <= 1'b1;
        end else begin
            wp <= next_wp;
            rp <= next_rp;
            cnt <= next_cnt;
            in_ready_o <= next_ready;
        end
    end

    // Storage needs no reset; a word is read only after it was written
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wp] <= in_data_i;
        end
    end
endmodule

// ### design/ccs_host_end.sv
// Purpose: Host serial port end facing one dual codec
// Assumes: User side on clk_i; link side on the link clock from the bench
// Notes: Words cross by toggle handshakes; one transmit word in flight
`timescale 1ns/1ps
`include "ccs_consts.svh"
module ccs_host_end (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Link to the codec
    ccs_link_if.host lnk,
    // Configuration
    input wire logic fslb_i,
    input wire logic se_i,
    input wire logic codec_rst_n_i,
    // Transmit words
    input wire logic tx_valid_i,
    input ccs_pkg::ccs_word_t tx_data_i,
    output logic tx_ready_o,
    // Received words
    output logic rx_valid_o,
    output ccs_pkg::ccs_word_t rx_data_o
);
    ccs_pkg::ccs_word_t hold, next_hold, rx_word, next_rx_word, tsh, next_tsh, rsh, next_rsh;
    logic req_t, next_req, ack_m, ack_s;
    logic rx_m, rx_s, rx_p, next_rx_valid;
    logic se_q, cr_q, fb_q;
    logic rq_m, rq_s, ack_t, next_ack, fb_m, fb_s, rx_t, next_rx_t;
    logic hfs, next_hfs, hsd, next_hsd, pend;
    logic [4:0] tbits, next_tbits, rbits, next_rbits;

    assign lnk.serial_port_enable_pin = se_q;
    assign lnk.codec_rst_n = cr_q;
    assign lnk.fslb = fb_q;
    assign lnk.host_tx_fs = hfs;
    assign lnk.serial_data_in_pin = hsd;

    // User side: one word held until the link side acknowledges it
    always_comb begin
        next_hold = hold;
        next_req = req_t;
        if (tx_valid_i && tx_ready_o) begin
            next_hold = tx_data_i;
            next_req = ~req_t;
        end
        next_rx_valid = (rx_s != rx_p);
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hold <= '0;
            req_t <= 1'b0;
            tx_ready_o <= 1'b0;
            ack_m <= 1'b0;
            ack_s <= 1'b0;
            rx_m <= 1'b0;
            rx_s <= 1'b0;
            rx_p <= 1'b0;
            rx_valid_o <= 1'b0;
            rx_data_o <= '0;
            se_q <= 1'b0;
            cr_q <= 1'b0;
            fb_q <= 1'b0;
        end else begin
            hold <= next_hold;
            req_t <= next_req;
            tx_ready_o <= (next_req == ack_s);
            ack_m <= ack_t;
            ack_s <= ack_m;
            rx_m <= rx_t;
            rx_s <= rx_m;
            rx_p <= rx_s;
            rx_valid_o <= next_rx_valid;
            // Word is stable for many link clocks after its toggle
            rx_data_o <= next_rx_valid ? rx_word : rx_data_o;
            // Registered on the master clock so all devices see one edge
            se_q <= se_i;
            cr_q <= codec_rst_n_i;
            fb_q <= fslb_i;
        end
    end

    // Link side runs on the codec's clock, never one of its own
    always_comb begin
        pend = (rq_s != ack_t);
        next_tsh = tsh;
        next_tbits = tbits;
        next_ack = ack_t;
        next_hfs = 1'b0;
        next_hsd = 1'b0;
        if (tbits != 5'h0) begin
            next_hsd = tsh[15];
            next_tsh = {tsh[14:0], 1'b0};
            next_tbits = tbits - 5'h1;
            if (tbits == 5'h1) begin
                next_ack = ~ack_t;
            end
        end else if (pend && fb_s && lnk.output_frame_sync) begin
            // Loop-back: device frame sync times the word, MSB next clock
            next_hsd = hold[15];
            next_tsh = {hold[14:0], 1'b0};
            next_tbits = `CCS_WORD_BITS - 5'h1;
        end else if (pend && !fb_s && !hfs) begin
            // Own frame sync, one clock wide, one clock before the MSB
            next_hfs = 1'b1;
            next_tsh = hold;
            next_tbits = `CCS_WORD_BITS;
        end
        next_rsh = rsh;
        next_rbits = rbits;
        next_rx_word = rx_word;
        next_rx_t = rx_t;
        if (rbits != 5'h0) begin
            next_rsh = {rsh[14:0], lnk.serial_data_out_pin};
            next_rbits = rbits - 5'h1;
            if (rbits == 5'h1) begin
                next_rx_word = {rsh[14:0], lnk.serial_data_out_pin};
                next_rx_t = ~rx_t;
            end
        end else if (lnk.output_frame_sync) begin
            next_rbits = `CCS_WORD_BITS;
        end
    end

    always_ff @(posedge lnk.sclk or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rq_m <= 1'b0;
            rq_s <= 1'b0;
            fb_m <= 1'b0;
            fb_s <= 1'b0;
            ack_t <= 1'b0;
            tsh <= '0;
            tbits <= 5'h0;
            hfs <= 1'b0;
            hsd <= 1'b0;
            rsh <= '0;
            rbits <= 5'h0;
            rx_word <= '0;
            rx_t <= 1'b0;
        end else begin
            rq_m <= req_t;
            rq_s <= rq_m;
            fb_m <= fb_q;
            fb_s <= fb_m;
            ack_t <= next_ack;
            tsh <= next_tsh;
            tbits <= next_tbits;
            hfs <= next_hfs;
            hsd <= next_hsd;
            rsh <= next_rsh;
            rbits <= next_rbits;
            rx_word <= next_rx_word;
            rx_t <= next_rx_t;
        end
    end
endmodule

// ### tb/ccs_link_checker.sv
// Purpose: Concurrent checks on the serial link between host end and dual codec
// Assumes: All signals sampled on the link clock; fslb and enables are slow levels
// Notes: Frame gaps are counted in helper logic so no long repetition is needed
`timescale 1ns/1ps
module ccs_link_checker (
    // Link clock and reset
    input wire logic sclk,
    input wire logic rst_n_i,
    // Device side of the link
    input wire logic output_frame_sync,
    input wire logic serial_data_out_pin,
    input wire logic input_frame_sync,
    // Host side of the link
    input wire logic serial_data_in_pin,
    input wire logic host_tx_fs,
    input wire logic fslb,
    input wire logic serial_port_enable_pin,
    input wire logic codec_rst_n
);
    logic [6:0] gap;
    logic [6:0] next_gap;
    logic [6:0] hgap;
    logic [6:0] next_hgap;
    logic seen;
    logic next_seen;
    logic hseen;
    logic next_hseen;

    default clocking cb @(posedge sclk);
    endclocking
    default disable iff (!rst_n_i);

    // Forget the framing whenever the device is held off, so a restart is not a gap
    always_comb begin
        next_gap = output_frame_sync ? 7'h01 : ((gap == 7'h7f) ? gap : gap + 7'h01);
        next_hgap = host_tx_fs ? 7'h01 : ((hgap == 7'h7f) ? hgap : hgap + 7'h01);
        next_seen = serial_port_enable_pin && codec_rst_n && (seen || output_frame_sync);
        next_hseen = hseen || host_tx_fs;
    end

    always_ff @(posedge sclk or negedge rst_n_i) begin
        if (!rst_n_i) begin
            gap <= 7'h7f;
            hgap <= 7'h7f;
            seen <= 1'b0;
            hseen <= 1'b0;
        end else begin
            gap <= next_gap;
            hgap <= next_hgap;
            seen <= next_seen;
            hseen <= next_hseen;
        end
    end

    AST_FS_ONE_CYCLE: assert property (output_frame_sync |=> !output_frame_sync)
        else $error("device frame sync longer than one cycle");
    AST_FS_SPACING: assert property (seen && output_frame_sync |-> gap == 7'h11 || gap == 7'h2f)
        else $error("device frame syncs not two per period");
    AST_FS_NO_DATA: assert property (output_frame_sync |-> !serial_data_out_pin)
        else $error("device data high in frame sync cycle");
    AST_IFS_NO_DATA: assert property (input_frame_sync |-> !serial_data_in_pin)
        else $error("host data high in frame sync cycle");
    AST_DATA_IDLE: assert property (seen && !output_frame_sync && gap > 7'h10 |-> !serial_data_out_pin)
        else $error("device data beyond sixteen bits");
    AST_SE_OFF: assert property ((!serial_port_enable_pin) [*4] |-> !output_frame_sync)
        else $error("frame sent while port disabled");
    AST_RST_OFF: assert property ((!codec_rst_n) [*4] |-> !output_frame_sync)
        else $error("frame sent while codec in reset");
    AST_HOST_FS_ONE: assert property (host_tx_fs |=> !host_tx_fs)
        else $error("host frame sync longer than one cycle");
    AST_HOST_FS_GAP: assert property (hseen && host_tx_fs |-> hgap > 7'h10)
        else $error("host frame sync inside a word");
    AST_LB_NO_HOST_FS: assert property (fslb [*4] |-> !host_tx_fs)
        else $error("host drove frame sync in loop-back");
endmodule

// ### tb/tb.sv
// Purpose: Self-checking bench joining host end and dual codec end over the link
// Assumes: Link clock 12 ns from the bench; host word in flight one at a time
// Notes: DAC words are sent just after a period start so both land in one period
`timescale 1ns/1ps
module tb;
    logic clk_i = 1'b0;
    logic sclk = 1'b0;
    logic rst_n_i = 1'b0;
    logic fslb_i = 1'b0;
    logic se_i = 1'b1;
    logic codec_rst_n_i = 1'b1;
    logic tx_valid_i = 1'b0;
    ccs_pkg::ccs_word_t tx_data_i = 16'h0000;
    logic tx_ready_o, rx_valid_o, adc_ready_o, dac_load_o;
    ccs_pkg::ccs_word_t rx_data_o, dac_ch1_o, dac_ch2_o;
    logic adc_valid_i = 1'b0;
    ccs_pkg::ccs_word_t adc_data_i = 16'h0000;
    logic [2:0] dev_count_o;
    logic [15:0] rx_q[$];
    logic saw_load = 1'b0;
    int num_errors = 0;
    int samples_checked = 0;
    int cycles = 0;

    initial forever #4 clk_i = ~clk_i;
    initial forever #6 sclk = ~sclk;

    ccs_link_if i_ccs_link_if (.sclk(sclk));
    ccs_host_end i_ccs_host_end (.clk_i(clk_i), .rst_n_i(rst_n_i), .lnk(i_ccs_link_if),
        .fslb_i(fslb_i), .se_i(se_i), .codec_rst_n_i(codec_rst_n_i), .tx_valid_i(tx_valid_i),
        .tx_data_i(tx_data_i), .tx_ready_o(tx_ready_o), .rx_valid_o(rx_valid_o),
        .rx_data_o(rx_data_o));
    ccs_codec_dev i_ccs_codec_dev (.lnk(i_ccs_link_if), .rst_n_i(rst_n_i),
        .adc_valid_i(adc_valid_i), .adc_data_i(adc_data_i), .adc_ready_o(adc_ready_o),
        .dac_ch1_o(dac_ch1_o), .dac_ch2_o(dac_ch2_o), .dac_load_o(dac_load_o),
        .dev_count_o(dev_count_o));
    ccs_link_checker i_ccs_link_checker (.sclk(sclk), .rst_n_i(rst_n_i),
        .output_frame_sync(i_ccs_link_if.output_frame_sync),
        .serial_data_out_pin(i_ccs_link_if.serial_data_out_pin),
        .input_frame_sync(i_ccs_link_if.input_frame_sync),
        .serial_data_in_pin(i_ccs_link_if.serial_data_in_pin),
        .host_tx_fs(i_ccs_link_if.host_tx_fs), .fslb(i_ccs_link_if.fslb),
        .serial_port_enable_pin(i_ccs_link_if.serial_port_enable_pin),
        .codec_rst_n(i_ccs_link_if.codec_rst_n));

    always @(negedge clk_i) if (rx_valid_o === 1'b1) rx_q.push_back(rx_data_o);
    always @(posedge sclk) if (dac_load_o === 1'b1) saw_load <= 1'b1;

    task automatic give_verdict();
        $display("Checks made %0d, mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 60000) begin
            num_errors++;
            give_verdict();
        end
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Holds the word until the edge that takes it, then releases one half cycle later
    task automatic send(input ccs_pkg::ccs_word_t w);
        int n;
        n = 0;
        @(negedge clk_i);
        tx_valid_i = 1'b1;
        tx_data_i = w;
        while (tx_ready_o !== 1'b1 && n < 2000) begin
            @(negedge clk_i);
            n++;
        end
        if (n == 2000) num_errors++;
        @(posedge clk_i);
        @(negedge clk_i);
        tx_valid_i = 1'b0;
    endtask

    task automatic get_rx(output logic [15:0] w);
        int n;
        n = 0;
        while (rx_q.size() == 0 && n < 5000) begin
            @(posedge clk_i);
            n++;
        end
        w = (rx_q.size() == 0) ? 16'hxxxx : rx_q.pop_front();
    endtask

    task automatic wait_load();
        int n;
        n = 0;
        do begin
            @(negedge sclk);
            n++;
        end while (dac_load_o !== 1'b1 && n < 300);
        if (dac_load_o !== 1'b1) num_errors++;
        @(negedge sclk);
    endtask

    task automatic t_program_idle();
        logic [15:0] w;
        rx_q.delete();
        repeat (4) begin
            get_rx(w);
            check("idle adc word", w, 16'h0000);
        end
        send(16'h8121);
        repeat (100) @(negedge clk_i);
        check("dev count", {13'h0000, dev_count_o}, 16'h0000);
        check("dac load", {15'h0000, saw_load}, 16'h0000);
    endtask

    // Program mode never pops, so the buffer must fill and then refuse
    task automatic t_fill_then_mixed();
        int acc;
        int got;
        logic [15:0] w;
        acc = 0;
        got = 0;
        repeat (20) begin
            @(negedge sclk);
            adc_valid_i = (adc_ready_o === 1'b1);
            adc_data_i = 16'h1001 + 16'(acc);
            if (adc_ready_o === 1'b1) acc++;
        end
        @(negedge sclk);
        adc_valid_i = 1'b0;
        check("accepted", 16'(acc), 16'h0010);
        check("ready full", {15'h0000, adc_ready_o}, 16'h0000);
        send(16'h8822);
        send(16'h8022);
        for (int k = 0; k < 60 && got < 16; k++) begin
            get_rx(w);
            if (w !== 16'h0000) begin
                check("adc order", w, 16'h1001 + 16'(got));
                got++;
            end
        end
        get_rx(w);
        check("adc empty", w, 16'h0000);
        check("adc count", 16'(got), 16'h0010);
        check("dev count", {13'h0000, dev_count_o}, 16'h0001);
    endtask

    task automatic t_dac(input ccs_pkg::ccs_word_t a, input ccs_pkg::ccs_word_t b,
                         input ccs_pkg::ccs_word_t e2, input ccs_pkg::ccs_word_t e1);
        wait_load();
        send(a);
        send(b);
        wait_load();
        check("dac codec 2", dac_ch2_o, e2);
        check("dac codec 1", dac_ch1_o, e1);
    endtask

    task automatic t_loopback();
        logic [15:0] w;
        fslb_i = 1'b1;
        repeat (40) @(negedge clk_i);
        send(16'h8042);
        rx_q.delete();
        repeat (3) get_rx(w);
        check("loop-back adc word", w, 16'h0000);
        check("dev count", {13'h0000, dev_count_o}, 16'h0002);
        repeat (3) get_rx(w);
    endtask

    task automatic t_reset_data();
        codec_rst_n_i = 1'b0;
        fslb_i = 1'b0;
        repeat (20) @(negedge clk_i);
        check("dev count cleared", {13'h0000, dev_count_o}, 16'h0000);
        codec_rst_n_i = 1'b1;
        repeat (20) @(negedge clk_i);
        send(16'h8821);
        send(16'h8021);
        repeat (40) @(negedge clk_i);
        // Data mode takes a flagged word as a DAC sample
        t_dac(16'h9234, 16'h0101, 16'h9234, 16'h0101);
    endtask

    task automatic t_se_off();
        se_i = 1'b0;
        repeat (50) @(negedge clk_i);
        rx_q.delete();
        repeat (300) @(negedge clk_i);
        check("words while disabled", 16'(rx_q.size()), 16'h0000);
        se_i = 1'b1;
    endtask

    initial begin
        repeat (8) @(negedge clk_i);
        rst_n_i = 1'b1;
        repeat (10) @(negedge clk_i);
        t_program_idle();
        t_fill_then_mixed();
        t_dac(16'h0a5a, 16'h05a5, 16'h0a5a, 16'h05a5);
        t_dac(16'h8022, 16'h0c3c, 16'h0c3c, 16'h05a5);
        t_loopback();
        t_reset_data();
        t_se_off();
        give_verdict();
    end
endmodule
